// ### logic/ecc_device.sv
// Purpose: Counter control end: transfer gate, count source, wave output
// Assumes: Pins event gate and supply sense are asynchronous
// Notes:   Crystal rate made by enable pulses from the system clock
`timescale 1ns/1ps
// Function
// - Hold bit one clears and holds slow wave prescaler stages
// - Hold resets only wave rates below 4096Hz
// - Hold bit zero restarts wave from cleared state
// - Gate one refreshes copy each tick, else frozen
// - Host clears gate before reading time bytes
// - Gate held 244us guarantees one transfer
// - Host loads time: gate off, write, gate on
// - Host avoids clearing gate during busy transfer
// - Oscillator-run bit enables crystal ticks
// - Source 00 counts on every tick
// - Source 01 counts on event pin and supply
// - Source 10 main supply, 11 battery only
// - Level sense bit picks event pin polarity
// - Wave enable outputs selected wave rate
// - Wave disabled drives zero; power fail releases
// - Wave prescaler independent of periodic chain
// - Hold aligns wave to other events
// - Periodic mask gates periodic flag to irq
// - Alarm mask gates alarm flag to irq
// - Periodic rate code selects flag rate
// - Wave rate code selects sixteen frequencies
// - Seconds equal alarm sets alarm flag
// - Status write clears periodic and alarm flags
module ecc_device (
  input  wire logic clk,
  input  wire logic resetn,
  ecc_bus_if.dev    bus,
  input  wire logic event_gate_pin,
  input  wire logic main_supply_ok,
  input  wire logic on_battery,
  output logic      wave_out_pin,
  output logic      wave_oe
);
  logic [2:0]                   s1_q, s2_q, s3_q, pin_q;
  logic [10:0]                  half_cnt_q;
  logic                         half_ph_q;
  logic [2:0]                   ph8_q;
  logic                         half_tick, xtal_tick, count_tick;
  logic [7:0]                   ctla_q, ctlb_q;
  logic                         hold_q;
  logic [31:0]                  alarm_q;
  logic [ecc_pkg::TIME_W-1:0]   copy_q, live_q, live_inc;
  logic                         load_q;
  logic                         count_en;
  logic                         pf_q, alm_q, osf_q, busy_q;
  logic [ecc_pkg::PER_W-1:0]    per_q, per_inc, per_mask;
  logic [ecc_pkg::WAVE_W-1:0]   wave_q, wave_inc;
  logic [4:0]                   wave_idx;
  logic                         osc, wen, stat_wr, time_wr;
  logic                         evt, mains, batt;
  logic [7:0]                   rdata_q;
  logic                         rvalid_q, irq_n_q;

  assign osc     = ctla_q[ecc_pkg::CA_OSC];
  assign wen     = bus.sel & bus.wr;
  assign stat_wr = wen & (bus.addr == ecc_pkg::ADDR_STAT);
  assign time_wr = wen & (bus.addr <= ecc_pkg::ADDR_SEC3);
  assign evt     = pin_q[2];
  assign mains   = pin_q[1];
  assign batt    = pin_q[0];

  // Pin inputs: change accepted once second and third stage agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q  <= 3'h0;
      s2_q  <= 3'h0;
      s3_q  <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      s1_q  <= {event_gate_pin, main_supply_ok, on_battery};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (pin_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
    end
  end

  // crystal ticks only run
  // while the oscillator bit is set
  assign half_tick  = osc &
      (half_cnt_q == 11'(ecc_pkg::HALF_XTAL_CYC - 1));
  assign xtal_tick  = half_tick & half_ph_q;
  assign count_tick = xtal_tick & (ph8_q == 3'(ecc_pkg::TICK_DIV - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      half_cnt_q <= 11'h0;
      half_ph_q  <= 1'b0;
      ph8_q      <= 3'h0;
    end else if (!osc) begin
      half_cnt_q <= 11'h0;
    end else begin
      half_cnt_q <= half_tick ? 11'h0 : half_cnt_q + 11'h1;
      if (half_tick)
        half_ph_q <= ~half_ph_q;
      if (xtal_tick)
        ph8_q <= ph8_q + 3'h1;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctla_q  <= ecc_pkg::CTLA_RST;
      ctlb_q  <= ecc_pkg::CTLB_RST;
      alarm_q <= 32'h0;
      hold_q  <= 1'b0;
    end else if (wen) begin
      if (bus.addr == ecc_pkg::ADDR_CTLA)
        ctla_q <= bus.wdata;
      if (bus.addr == ecc_pkg::ADDR_CTLB)
        ctlb_q <= bus.wdata;
      if (bus.addr >= ecc_pkg::ADDR_ALM0 && bus.addr <= ecc_pkg::ADDR_ALM3)
        alarm_q[8*(bus.addr - ecc_pkg::ADDR_ALM0) +: 8] <= bus.wdata;
      // hold bit sits in lowest fraction byte
      if (bus.addr == ecc_pkg::ADDR_SUB0)
        hold_q <= bus.wdata[ecc_pkg::SUB0_HOLD];
    end
  end

  // source field picks the counting condition
  always_comb begin
    case (ecc_pkg::ecc_src_e'(ctla_q[ecc_pkg::CA_SRC +: 2]))
      ecc_pkg::SRC_ALWAYS: count_en = 1'b1;
      // event level and supply both needed
      ecc_pkg::SRC_EVENT:  count_en = mains &
                                      (evt == ctla_q[ecc_pkg::CA_POL]);
      ecc_pkg::SRC_MAIN:   count_en = ~batt;
      ecc_pkg::SRC_BATT:   count_en = batt;
      default:             count_en = 1'b0;
    endcase
  end

  assign live_inc = live_q + ecc_pkg::TIME_W'(1);

  // Live count, host copy and pending load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live_q <= '0;
      copy_q <= '0;
      load_q <= 1'b0;
    end else begin
      if (count_tick && count_en)
        live_q <= live_inc;
      // transfer on each tick while gate is open
      if (count_tick && ctla_q[ecc_pkg::CA_GATE]) begin
        if (load_q)
          live_q <= copy_q;
        else
          copy_q <= count_en ? live_inc : live_q;
        load_q <= 1'b0;
      end
      // host time writes are pushed into the count later
      if (time_wr) begin
        load_q <= 1'b1;
        if (bus.addr == ecc_pkg::ADDR_SUB0)
          copy_q[3:0] <= bus.wdata[7:4];
        else
          copy_q[8*bus.addr - 4 +: 8] <= bus.wdata;
      end
    end
  end

  // periodic chain apart from the wave prescaler
  assign per_inc  = per_q + ecc_pkg::PER_W'(1);
  assign per_mask = (ecc_pkg::PER_W'(1)
      << ecc_pkg::ecc_pf_shift(ctlb_q[ecc_pkg::CB_PRS +: 4]))
      - ecc_pkg::PER_W'(1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      per_q <= '0;
    else if (count_tick)
      per_q <= per_inc;
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pf_q   <= 1'b0;
      alm_q  <= 1'b0;
      osf_q  <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (stat_wr) begin
        pf_q  <= 1'b0;
        alm_q <= 1'b0;
        osf_q <= 1'b0;
      end
      // code zero never sets the flag
      if (count_tick && ctlb_q[ecc_pkg::CB_PRS +: 4] != 4'h0 &&
          (per_inc & per_mask) == '0)
        pf_q <= 1'b1;
      // seconds roll onto the alarm value
      if (count_tick && count_en &&
          live_q[ecc_pkg::SUB_W-1:0] == '1 &&
          live_inc[ecc_pkg::TIME_W-1:ecc_pkg::SUB_W] == alarm_q)
        alm_q <= 1'b1;
      if (!osc)
        osf_q <= 1'b1;
      // busy flags the crystal period before a transfer
      busy_q <= ctla_q[ecc_pkg::CA_GATE] & osc &
                (ph8_q == 3'(ecc_pkg::TICK_DIV - 1));
    end
  end

  // code zero is the raw crystal, code n is bit n+1
  assign wave_idx = (ctlb_q[ecc_pkg::CB_SRS +: 4] == 4'h0) ? 5'h00 :
                    {1'b0, ctlb_q[ecc_pkg::CB_SRS +: 4]} + 5'h01;
  assign wave_inc = wave_q + ecc_pkg::WAVE_W'(1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      wave_q <= '0;
    else if (hold_q)
      // slow stages held clear, fast ones run
      wave_q <= {{(ecc_pkg::WAVE_W - ecc_pkg::WAVE_HLO){1'b0}},
                 half_tick ? wave_inc[ecc_pkg::WAVE_HLO-1:0]
                           : wave_q[ecc_pkg::WAVE_HLO-1:0]};
    else if (half_tick)
      // runs on from the cleared state
      wave_q <= wave_inc;
  end

  // Outputs and register read port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wave_out_pin <= 1'b0;
      wave_oe      <= 1'b0;
      rdata_q      <= 8'h00;
      rvalid_q     <= 1'b0;
      irq_n_q      <= 1'b1;
    end else begin
      // zero when disabled, released in power fail
      wave_out_pin <= ctla_q[ecc_pkg::CA_WAVE] & osc & wave_q[wave_idx];
      wave_oe      <= mains;
      // masked flags pull the line low
      irq_n_q  <= ~((pf_q & ctla_q[ecc_pkg::CA_PIE]) |
                    (alm_q & ctla_q[ecc_pkg::CA_AIE]));
      rvalid_q <= bus.sel & ~bus.wr;
      if (bus.sel && !bus.wr) begin
        if (bus.addr == ecc_pkg::ADDR_SUB0)
          rdata_q <= {copy_q[3:0], 3'h0, hold_q};
        else if (bus.addr <= ecc_pkg::ADDR_SEC3)
          rdata_q <= copy_q[8*bus.addr - 4 +: 8];
        else if (bus.addr <= ecc_pkg::ADDR_ALM3)
          rdata_q <= alarm_q[8*(bus.addr - ecc_pkg::ADDR_ALM0) +: 8];
        else if (bus.addr == ecc_pkg::ADDR_CTLA)
          rdata_q <= ctla_q;
        else if (bus.addr == ecc_pkg::ADDR_CTLB)
          rdata_q <= ctlb_q;
        else if (bus.addr == ecc_pkg::ADDR_STAT)
          rdata_q <= {osf_q, busy_q, 4'h0, pf_q, alm_q};
        else
          rdata_q <= 8'h00;
      end
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign bus.irq_n  = irq_n_q;
endmodule : ecc_device

// ### logic/ecc_pkg.sv
// Purpose: Shared constants for the elapsed counter control ends
// Assumes: 125 MHz system clock, crystal rate derived by enable pulses
// Notes:   All register offsets and bit positions live here
package ecc_pkg;
  localparam int CLK_HZ        = 125_000_000;
  localparam int CLK_NS        = 8;
  localparam int XTAL_HZ       = 32768;
  // Half crystal period, longest time so rounded down
  localparam int HALF_XTAL_CYC = CLK_HZ / (2 * XTAL_HZ);
  localparam int TICK_DIV      = 8;
  localparam int GATE_HOLD_NS  = 244_000;
  // Least gate hold, rounded up to whole cycles
  localparam int GATE_HOLD_CYC = (GATE_HOLD_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [3:0] ADDR_SUB0 = 4'h0;
  localparam logic [3:0] ADDR_SEC3 = 4'h5;
  localparam logic [3:0] ADDR_ALM0 = 4'h6;
  localparam logic [3:0] ADDR_ALM3 = 4'h9;
  localparam logic [3:0] ADDR_CTLA = 4'ha;
  localparam logic [3:0] ADDR_CTLB = 4'hb;
  localparam logic [3:0] ADDR_STAT = 4'hc;

  localparam int CA_GATE = 7;
  localparam int CA_OSC  = 6;
  localparam int CA_SRC  = 4;
  localparam int CA_POL  = 3;
  localparam int CA_WAVE = 2;
  localparam int CA_PIE  = 1;
  localparam int CA_AIE  = 0;
  localparam int CB_PRS  = 4;
  localparam int CB_SRS  = 0;
  localparam int ST_OSF  = 7;
  localparam int ST_BUSY = 6;
  localparam int ST_PF   = 1;
  localparam int ST_ALM  = 0;
  localparam int SUB0_HOLD = 0;

  localparam logic [7:0] CTLA_RST = 8'h00;
  localparam logic [7:0] CTLB_RST = 8'h00;

  localparam int SUB_W    = 12;
  localparam int SEC_W    = 32;
  localparam int TIME_W   = SUB_W + SEC_W;
  localparam int WAVE_W   = 17;
  localparam int WAVE_HLO = 4;
  localparam int PER_W    = 34;

  typedef enum logic [1:0] {
    SRC_ALWAYS = 2'h0,
    SRC_EVENT  = 2'h1,
    SRC_MAIN   = 2'h2,
    SRC_BATT   = 2'h3
  } ecc_src_e;

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_CHECK = 5'h02,
    H_ISSUE = 5'h04,
    H_RWAIT = 5'h08,
    H_HOLD  = 5'h10
  } ecc_hstate_e;

  // Periodic flag period as a power of two of count ticks
  function automatic logic [5:0] ecc_pf_shift(input logic [3:0] code);
    case (code)
      4'h1:    ecc_pf_shift = 6'h00;
      4'h2:    ecc_pf_shift = 6'h01;
      4'h3:    ecc_pf_shift = 6'h02;
      4'h4:    ecc_pf_shift = 6'h03;
      4'h5:    ecc_pf_shift = 6'h04;
      4'h6:    ecc_pf_shift = 6'h05;
      4'h7:    ecc_pf_shift = 6'h09;
      4'h8:    ecc_pf_shift = 6'h0a;
      4'h9:    ecc_pf_shift = 6'h0b;
      4'ha:    ecc_pf_shift = 6'h0c;
      4'hb:    ecc_pf_shift = 6'h12;
      4'hc:    ecc_pf_shift = 6'h18;
      4'hd:    ecc_pf_shift = 6'h1c;
      4'he:    ecc_pf_shift = 6'h1f;
      default: ecc_pf_shift = 6'h21;
    endcase
  endfunction : ecc_pf_shift
endpackage : ecc_pkg

// ### logic/ecc_bus_if.sv
// Purpose: Byte-wide register port between host and counter device
// Assumes: Both ends on the same clock
// Notes:   Read data answers one cycle after the select
`timescale 1ns/1ps
interface ecc_bus_if;
  logic       sel;
  logic       wr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq_n;

  modport dev (input sel, input wr, input addr, input wdata,
               output rdata, output rvalid, output irq_n);
  modport host (output sel, output wr, output addr, output wdata,
                input rdata, input rvalid, input irq_n);
endinterface : ecc_bus_if

// ### logic/ecc_host.sv
// Purpose: Host end: issues register accesses for a user command port
// Assumes: Device answers reads one cycle after select
// Notes:   Guards gate clear against busy, holds after gate set
`timescale 1ns/1ps
module ecc_host #(
  parameter int GATE_HOLD_CYC = ecc_pkg::GATE_HOLD_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  ecc_bus_if.host         bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [3:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            irq_seen
);
  ecc_pkg::ecc_hstate_e state_q;
  logic                 wr_q, check_q;
  logic [3:0]           addr_q;
  logic [7:0]           wdata_q;
  logic                 sel_q, bwr_q;
  logic [3:0]           baddr_q;
  logic [7:0]           bwdata_q;
  logic [15:0]          hold_q;
  logic                 gate_on;

  assign gate_on = wr_q & (addr_q == ecc_pkg::ADDR_CTLA) &
                   wdata_q[ecc_pkg::CA_GATE];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= ecc_pkg::H_IDLE;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      irq_seen  <= 1'b0;
      wr_q      <= 1'b0;
      check_q   <= 1'b0;
      addr_q    <= 4'h0;
      wdata_q   <= 8'h00;
      sel_q     <= 1'b0;
      bwr_q     <= 1'b0;
      baddr_q   <= 4'h0;
      bwdata_q  <= 8'h00;
      hold_q    <= 16'h0;
    end else begin
      sel_q     <= 1'b0;
      rsp_valid <= 1'b0;
      irq_seen  <= ~bus.irq_n;
      case (state_q)
        ecc_pkg::H_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            wr_q      <= cmd_write;
            addr_q    <= cmd_addr;
            wdata_q   <= cmd_wdata;
            // clearing the gate waits for busy low
            if (cmd_write && cmd_addr == ecc_pkg::ADDR_CTLA &&
                !cmd_wdata[ecc_pkg::CA_GATE])
              state_q <= ecc_pkg::H_CHECK;
            else
              state_q <= ecc_pkg::H_ISSUE;
          end
        end
        ecc_pkg::H_CHECK: begin
          sel_q   <= 1'b1;
          bwr_q   <= 1'b0;
          baddr_q <= ecc_pkg::ADDR_STAT;
          check_q <= 1'b1;
          state_q <= ecc_pkg::H_RWAIT;
        end
        ecc_pkg::H_ISSUE: begin
          sel_q    <= 1'b1;
          bwr_q    <= wr_q;
          baddr_q  <= addr_q;
          bwdata_q <= wdata_q;
          check_q  <= 1'b0;
          hold_q   <= 16'h0;
          if (!wr_q)
            state_q <= ecc_pkg::H_RWAIT;
          else if (gate_on)
            state_q <= ecc_pkg::H_HOLD;
          else begin
            cmd_ready <= 1'b1;
            state_q   <= ecc_pkg::H_IDLE;
          end
        end
        ecc_pkg::H_RWAIT: begin
          if (bus.rvalid) begin
            if (!check_q) begin
              rsp_valid <= 1'b1;
              rsp_data  <= bus.rdata;
              cmd_ready <= 1'b1;
              state_q   <= ecc_pkg::H_IDLE;
            end else if (bus.rdata[ecc_pkg::ST_BUSY])
              state_q <= ecc_pkg::H_CHECK;
            else
              state_q <= ecc_pkg::H_ISSUE;
          end
        end
        ecc_pkg::H_HOLD: begin
          // gate stays open long enough for a transfer
          hold_q <= hold_q + 16'h1;
          if (hold_q == 16'(GATE_HOLD_CYC - 1)) begin
            cmd_ready <= 1'b1;
            state_q   <= ecc_pkg::H_IDLE;
          end
        end
        default: begin
          cmd_ready <= 1'b1;
          state_q   <= ecc_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign bus.sel   = sel_q;
  assign bus.wr    = bwr_q;
  assign bus.addr  = baddr_q;
  assign bus.wdata = bwdata_q;
endmodule : ecc_host

// ### bench/ecc_bus_monitor.sv
// Purpose: Checks on the register port between host and device
// Assumes: One clock domain, resetn async active low
// Notes:   Sees the interface signals only; shadows kept for compares
`timescale 1ns/1ps
module ecc_bus_monitor #(
  parameter int GATE_HOLD_CYC = ecc_pkg::GATE_HOLD_CYC
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       sel,
  input wire logic       wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq_n
);
  logic [7:0]  ctla_q;
  logic [7:0]  ctlb_q;
  logic [3:0]  rd_addr_q;
  logic [31:0] hold_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence rd_req;
    sel && !wr;
  endsequence
  sequence wr_ctla;
    sel && wr && addr == ecc_pkg::ADDR_CTLA;
  endsequence

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctla_q <= ecc_pkg::CTLA_RST;
    end else if (sel && wr && addr == ecc_pkg::ADDR_CTLA) begin
      ctla_q <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctlb_q <= ecc_pkg::CTLB_RST;
    end else if (sel && wr && addr == ecc_pkg::ADDR_CTLB) begin
      ctlb_q <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_addr_q <= 4'h0;
    end else if (sel && !wr) begin
      rd_addr_q <= addr;
    end
  end

  // Saturating count since gate set, so it cannot wrap in long runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 32'(GATE_HOLD_CYC);
    end else if (sel && wr && addr == ecc_pkg::ADDR_CTLA
                 && wdata[ecc_pkg::CA_GATE]) begin
      hold_q <= 32'h0;
    end else if (hold_q < 32'(GATE_HOLD_CYC)) begin
      hold_q <= hold_q + 32'h1;
    end
  end

  read_answer_a: assert property (rd_req |=> rvalid)
    else $error("read not answered next cycle");
  no_stray_a: assert property (!(sel && !wr) |=> !rvalid)
    else $error("answer without a read");
  rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without an answer");
  ctla_rw_a: assert property (
    rd_req ##0 addr == ecc_pkg::ADDR_CTLA |=> rdata == ctla_q)
    else $error("control A readback wrong");
  ctlb_rw_a: assert property (
    rd_req ##0 addr == ecc_pkg::ADDR_CTLB |=> rdata == ctlb_q)
    else $error("control B readback wrong");
  irq_mask_a: assert property (
    (!ctla_q[ecc_pkg::CA_PIE] && !ctla_q[ecc_pkg::CA_AIE]) [*2] |-> irq_n)
    else $error("interrupt low while masked");
  irq_clear_a: assert property (
    sel && wr && addr == ecc_pkg::ADDR_STAT |-> ##[1:3] irq_n)
    else $error("interrupt stays low after status write");
  gate_safe_a: assert property (
    wr_ctla ##0 !wdata[ecc_pkg::CA_GATE]
    |-> rd_addr_q == ecc_pkg::ADDR_STAT && !rdata[ecc_pkg::ST_BUSY])
    else $error("gate cleared without idle status");
  gate_hold_a: assert property (sel |-> hold_q >= GATE_HOLD_CYC)
    else $error("access before gate hold ran out");
endmodule : ecc_bus_monitor

// ### bench/elapsed_counter_control_tb.sv
// Purpose: Host and device joined by their port, driven by commands
// Assumes: 125 MHz clock, inputs driven on the falling edge
// Notes:   Count tick is 30512 clocks, so waits are long but bounded
`timescale 1ns/1ps
module elapsed_counter_control_tb;
  logic       clk;
  logic       resetn;
  logic       cmd_valid;
  logic       cmd_write;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       irq_seen;
  logic       main_supply_ok;
  logic       event_gate_pin;
  logic       on_battery;
  logic       wave_out_pin;
  logic       wave_oe;
  logic [7:0] rd;
  logic       tog;
  logic       irq_any;
  int         n_fail;
  int         cmp_count;

  ecc_bus_if bus ();

  ecc_host ecc_host_inst (
    .clk(clk), .resetn(resetn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .irq_seen(irq_seen));
  ecc_device ecc_device_inst (
    .clk(clk), .resetn(resetn), .bus(bus),
    .event_gate_pin(event_gate_pin),
    .main_supply_ok(main_supply_ok), .on_battery(on_battery),
    .wave_out_pin(wave_out_pin), .wave_oe(wave_oe));
  ecc_bus_monitor #(.GATE_HOLD_CYC(ecc_pkg::GATE_HOLD_CYC))
    ecc_bus_monitor_inst (
    .clk(clk), .resetn(resetn), .sel(bus.sel), .wr(bus.wr),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid), .irq_n(bus.irq_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_ready();
    for (int i = 0; i < 40000 && cmd_ready !== 1'b1; i++)
      @(negedge clk);
    if (cmd_ready !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: host never idle", $time);
      end_sim();
    end
  endtask : wait_ready

  // One byte per command; a gate set keeps the host busy a long time
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    if (!w) begin
      for (int i = 0; i < 16 && rsp_valid !== 1'b1; i++)
        @(negedge clk);
      rd = (rsp_valid === 1'b1) ? rsp_data : 8'hxx;
    end
    wait_ready();
  endtask : xfer

  task automatic watch(input int n);
    logic last;
    // Let a control write just made reach the registered pin first
    repeat (4) @(negedge clk);
    last = wave_out_pin;
    tog = 1'b0;
    irq_any = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (wave_out_pin !== last) tog = 1'b1;
      if (irq_seen !== 1'b0) irq_any = 1'b1;
      last = wave_out_pin;
    end
  endtask : watch

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 4'h0;
    cmd_wdata = 8'h00;
    main_supply_ok = 1'b1;
    event_gate_pin = 1'b0;
    on_battery = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    xfer(1'b0, ecc_pkg::ADDR_CTLA, 8'h00);
    chk(rd, ecc_pkg::CTLA_RST);
    xfer(1'b0, ecc_pkg::ADDR_CTLB, 8'h00);
    chk(rd, ecc_pkg::CTLB_RST);
    xfer(1'b1, ecc_pkg::ADDR_CTLB, 8'h12);
    xfer(1'b0, ecc_pkg::ADDR_CTLB, 8'h00);
    chk(rd, 8'h12);
    xfer(1'b1, 4'he, 8'h5a);
    xfer(1'b0, 4'he, 8'h00);
    chk(rd, 8'h00);
    $display("Test registers done");
    // Hold on: 2048 Hz frozen, 4096 Hz still running, irqs masked
    xfer(1'b1, ecc_pkg::ADDR_CTLA, 8'h44);
    xfer(1'b1, ecc_pkg::ADDR_SUB0, 8'h01);
    xfer(1'b1, ecc_pkg::ADDR_CTLB, 8'h13);
    watch(15500);
    chk(8'(tog), 8'h00);
    chk(8'(wave_out_pin), 8'h00);
    xfer(1'b1, ecc_pkg::ADDR_CTLB, 8'h12);
    watch(15500);
    chk(8'(tog), 8'h01);
    chk(8'(irq_any), 8'h00);
    xfer(1'b0, ecc_pkg::ADDR_STAT, 8'h00);
    chk(rd & 8'h03, 8'h02);
    xfer(1'b1, ecc_pkg::ADDR_STAT, 8'h00);
    xfer(1'b0, ecc_pkg::ADDR_STAT, 8'h00);
    chk(rd & 8'h03, 8'h00);
    $display("Test hold and mask done");
    // Load seconds with gate off, then gate on across one tick
    // gate off, write, gate on
    xfer(1'b1, 4'h2, 8'h33);
    xfer(1'b1, ecc_pkg::ADDR_CTLA, 8'hc6);
    chk(8'(irq_seen), 8'h01);
    xfer(1'b1, ecc_pkg::ADDR_CTLA, 8'h46);
    xfer(1'b0, 4'h2, 8'h00);
    chk(rd, 8'h33);
    xfer(1'b1, ecc_pkg::ADDR_STAT, 8'h00);
    for (int i = 0; i < 8 && irq_seen !== 1'b0; i++)
      @(negedge clk);
    chk(8'(irq_seen), 8'h00);
    $display("Test transfer done");
    xfer(1'b1, ecc_pkg::ADDR_CTLB, 8'h13);
    xfer(1'b1, ecc_pkg::ADDR_SUB0, 8'h00);
    watch(31000);
    chk(8'(tog), 8'h01);
    $display("Test release done");
    xfer(1'b1, ecc_pkg::ADDR_CTLB, 8'h10);
    xfer(1'b1, ecc_pkg::ADDR_CTLA, 8'h40);
    watch(4000);
    chk(8'({tog, wave_out_pin}), 8'h00);
    chk(8'(wave_oe), 8'h01);
    main_supply_ok = 1'b0;
    for (int i = 0; i < 8 && wave_oe !== 1'b0; i++)
      @(negedge clk);
    chk(8'(wave_oe), 8'h00);
    $display("Test wave off done");
    end_sim();
  end
endmodule : elapsed_counter_control_tb
